// ---- verilog/fps_map.vh ----
`ifndef FPS_MAP_VH
`define FPS_MAP_VH

// register word indices; byte address is four times the index
`define FPS_IDX_DIV 6'h02
`define FPS_IDX_CFG 6'h03
`define FPS_IDX_PROT 6'h04
`define FPS_IDX_STAT 6'h05
`define FPS_IDX_CMD 6'h06

// status register bit positions
`define FPS_BIT_BUFEMPTY 7
`define FPS_BIT_COMPLETE 6
`define FPS_BIT_PROTECTION_VIOLATION_FLAG 5
`define FPS_BIT_ACCESS_ERROR_FLAG 4
`define FPS_BIT_BLANK 2
`define FPS_BIT_FAIL 1
`define FPS_BIT_DONE 0

// config register bit positions
`define FPS_BIT_BEIE 7
`define FPS_BIT_COMPLETE_IRQ_ENABLE 6

// reset values
`define FPS_RST_PROT 3'h7
`define FPS_RST_CFG 2'h0
`define FPS_RST_DIV 8'h00
`define FPS_RST_CMD 8'h00

// allowed target scenarios per source scenario, bit n = target n
`define FPS_ALLOW_0 8'h0f
`define FPS_ALLOW_1 8'h0a
`define FPS_ALLOW_2 8'h0c
`define FPS_ALLOW_3 8'h08
`define FPS_ALLOW_4 8'h18
`define FPS_ALLOW_5 8'h3c
`define FPS_ALLOW_6 8'h5a
`define FPS_ALLOW_7 8'hff

// valid command codes
`define FPS_CMD_VERIFY 8'h05
`define FPS_CMD_PROGRAM 8'h20
`define FPS_CMD_SECTOR 8'h40
`define FPS_CMD_MASS 8'h41

`endif

// ---- verilog/fps_prot_guard.v ----
`timescale 1ns/1ps
`include "fps_map.vh"

module fps_prot_guard (
  input wire [2:0] curScen,
  input wire [2:0] reqScen,
  output reg allow
);

  reg [7:0] mask;

  // permitted target set for the scenario now in force
  always @* begin
    case (curScen)
      3'h0: mask = `FPS_ALLOW_0;
      3'h1: mask = `FPS_ALLOW_1;
      3'h2: mask = `FPS_ALLOW_2;
      3'h3: mask = `FPS_ALLOW_3;
      3'h4: mask = `FPS_ALLOW_4;
      3'h5: mask = `FPS_ALLOW_5;
      3'h6: mask = `FPS_ALLOW_6;
      default: mask = `FPS_ALLOW_7;
    endcase
    allow = mask[reqScen];
  end

endmodule

// ---- verilog/fps_ctrl.v ----
// How it works
// - forbidden protection change requests are dropped, register kept
// - only listed scenario transitions are accepted by protection
// - reading protection returns the scenario in force
// - normal mode: fail and done read zero, complete and blank read-only
// - special mode: fail is clearable, done is read-only
// - status bit 7 shows buffers empty; writing 1 launches, 0 acts only mid sequence
// - zero to buffer-empty mid sequence aborts it and sets access error
// - zero to buffer-empty outside a sequence sets no access error
// - buffer-empty interrupt request while flag and its enable are set
// - complete clears with buffer-empty clear, sets only when all finished
// - complete ignores writes; interrupt request with its enable
// - violation flag sets on protected program or erase, write 1 clears
// - no launch while protection violation is set
// - access error on sequence violation, illegal code, or stop while busy
// - access error clears by writing 1; no launch while set
// - blank sets on erased verify, clears at valid launch, ignores writes
// - blank stays zero after a verify that finds the array not erased
// - special mode fail sets on failed verify, write 1 clears, blocks launch
// - special mode done is zero while an operation is active
// - status register sits at index 0x5
// - launch without a divider write since reset sets access error instead
`timescale 1ns/1ps
`include "fps_map.vh"

module fps_ctrl (
  input wire sys_clk,
  input wire rstn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire hready,
  input wire [31:0] hwdata,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire specialModePin,
  input wire flashWordWr,
  input wire engineTake,
  input wire engineBusy,
  input wire engineDone,
  input wire protHit,
  input wire verifyBlank,
  input wire verifyFail,
  input wire stopReq,
  output reg launchValid,
  output reg [7:0] launchCmd,
  output reg [2:0] protScenario,
  output reg [7:0] timebaseDiv,
  output reg irqBufEmpty,
  output reg irqComplete
);

  localparam SEQ_IDLE = 2'h0;
  localparam SEQ_ADDR = 2'h1;
  localparam SEQ_CMD = 2'h2;

  localparam SEL_NONE = 3'h0;
  localparam SEL_DIV = 3'h1;
  localparam SEL_CFG = 3'h2;
  localparam SEL_PROT = 3'h3;
  localparam SEL_STAT = 3'h4;
  localparam SEL_CMD = 3'h5;

  // register select from a word index; upper address bits must be zero
  function [2:0] decodeSel;
    input [31:0] addr;
    begin
      if (addr[31:8] != 24'h000000) begin
        decodeSel = SEL_NONE;
      end else if (addr[7:2] == `FPS_IDX_DIV) begin
        decodeSel = SEL_DIV;
      end else if (addr[7:2] == `FPS_IDX_CFG) begin
        decodeSel = SEL_CFG;
      end else if (addr[7:2] == `FPS_IDX_PROT) begin
        decodeSel = SEL_PROT;
      end else if (addr[7:2] == `FPS_IDX_STAT) begin
        decodeSel = SEL_STAT;
      end else if (addr[7:2] == `FPS_IDX_CMD) begin
        decodeSel = SEL_CMD;
      end else begin
        decodeSel = SEL_NONE;
      end
    end
  endfunction

  // legal command codes
  function isValidCmd;
    input [7:0] code;
    begin
      isValidCmd = (code == `FPS_CMD_VERIFY) || (code == `FPS_CMD_PROGRAM) ||
        (code == `FPS_CMD_SECTOR) || (code == `FPS_CMD_MASS);
    end
  endfunction

  reg rstMeta_reg, rstSyncN;
  reg modeMeta_reg, special_reg;
  reg xferPend_reg;
  reg xferWr_reg;
  reg [2:0] xferSel_reg;
  reg [1:0] seq_reg, seq_next;
  reg bufFull_reg, bufFull_next;
  reg cmd_complete_flag_reg, cmd_complete_flag_next;
  reg protection_violation_flag_reg, protection_violation_flag_next;
  reg access_error_flag_reg, access_error_flag_next;
  reg blank_reg, blank_next;
  reg fail_reg, fail_next;
  reg done_reg;
  reg divLoaded_reg;
  reg [1:0] cfg_reg;
  reg [7:0] cmdCode_reg, cmdCode_next;
  reg [7:0] rdByte;
  reg seqErr;
  reg launch;
  wire protAllow, wrStb, wrStat, wrCmd;
  wire wrOther, launchReq, zeroWr, errBlock;

  // reset release through two flip-flops
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rstMeta_reg <= 1'b0;
      rstSyncN <= 1'b0;
    end else begin
      rstMeta_reg <= 1'b1;
      rstSyncN <= rstMeta_reg;
    end
  end

  // mode pin synchroniser
  always @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      modeMeta_reg <= 1'b0;
      special_reg <= 1'b0;
    end else begin
      modeMeta_reg <= specialModePin;
      special_reg <= modeMeta_reg;
    end
  end

  // bus slave: one wait state per transfer, data handled in its first cycle
  always @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      xferPend_reg <= 1'b0;
      xferWr_reg <= 1'b0;
      xferSel_reg <= SEL_NONE;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
    end else begin
      hresp <= 1'b0;
      if (xferPend_reg) begin
        xferPend_reg <= 1'b0;
        hreadyout <= 1'b1;
        if (!xferWr_reg) begin
          hrdata <= {24'h000000, rdByte};
        end
      end else if (hsel && htrans[1] && hready) begin
        xferPend_reg <= 1'b1;
        xferWr_reg <= hwrite;
        xferSel_reg <= decodeSel(haddr);
        hreadyout <= 1'b0;
      end
    end
  end

  assign wrStb = xferPend_reg && xferWr_reg;
  assign wrStat = wrStb && (xferSel_reg == SEL_STAT);
  assign wrCmd = wrStb && (xferSel_reg == SEL_CMD);
  assign wrOther = wrStb && ((xferSel_reg == SEL_DIV) ||
    (xferSel_reg == SEL_CFG) || (xferSel_reg == SEL_PROT));
  assign launchReq = wrStat && hwdata[`FPS_BIT_BUFEMPTY];
  assign zeroWr = wrStat && !hwdata[`FPS_BIT_BUFEMPTY];
  assign errBlock = protection_violation_flag_reg || access_error_flag_reg || (special_reg && fail_reg);

  // read mux
  always @* begin
    rdByte = 8'h00;
    case (xferSel_reg)
      SEL_DIV: rdByte = timebaseDiv;
      SEL_CFG: rdByte = {cfg_reg, 6'h00};
      SEL_PROT: rdByte = {5'h00, protScenario};
      SEL_CMD: rdByte = cmdCode_reg;
      SEL_STAT: begin
        rdByte[`FPS_BIT_BUFEMPTY] = !bufFull_reg;
        rdByte[`FPS_BIT_COMPLETE] = cmd_complete_flag_reg;
        rdByte[`FPS_BIT_PROTECTION_VIOLATION_FLAG] = protection_violation_flag_reg;
        rdByte[`FPS_BIT_ACCESS_ERROR_FLAG] = access_error_flag_reg;
        rdByte[`FPS_BIT_BLANK] = blank_reg;
        rdByte[`FPS_BIT_FAIL] = special_reg && fail_reg;
        rdByte[`FPS_BIT_DONE] = special_reg && done_reg;
      end
      default: rdByte = 8'h00;
    endcase
  end

  // command write sequence supervisor
  always @* begin
    seq_next = seq_reg;
    cmdCode_next = cmdCode_reg;
    seqErr = 1'b0;
    launch = 1'b0;
    case (seq_reg)
      SEQ_IDLE: begin
        if (flashWordWr) begin
          if (bufFull_reg) begin
            seqErr = 1'b1;
          end else if (!errBlock) begin
            seq_next = SEQ_ADDR;
          end
        end else if (wrCmd || launchReq) begin
          seqErr = 1'b1;
        end
      end
      SEQ_ADDR: begin
        if (flashWordWr || launchReq || wrOther) begin
          seqErr = 1'b1;
          seq_next = SEQ_IDLE;
        end else if (zeroWr) begin
          seqErr = 1'b1;
          seq_next = SEQ_IDLE;
        end else if (wrCmd) begin
          cmdCode_next = hwdata[7:0];
          seq_next = SEQ_CMD;
        end
      end
      SEQ_CMD: begin
        if (flashWordWr || wrCmd || wrOther) begin
          seqErr = 1'b1;
          seq_next = SEQ_IDLE;
        end else if (zeroWr) begin
          seqErr = 1'b1;
          seq_next = SEQ_IDLE;
        end else if (launchReq) begin
          seq_next = SEQ_IDLE;
          if (!divLoaded_reg) begin
            seqErr = 1'b1;
          end else if (!isValidCmd(cmdCode_reg)) begin
            seqErr = 1'b1;
          end else if (!errBlock) begin
            launch = 1'b1;
          end
        end
      end
      default: seq_next = SEQ_IDLE;
    endcase
  end

  // status flag next values; hardware set wins over software clear, except launch wins over engineTake and engineDone
  always @* begin
    bufFull_next = bufFull_reg;
    if (launch) begin
      bufFull_next = 1'b1;
    end else if (engineTake) begin
      bufFull_next = 1'b0;
    end
    cmd_complete_flag_next = cmd_complete_flag_reg;
    if (bufFull_next) begin
      cmd_complete_flag_next = 1'b0;
    end else if (engineDone && !engineTake) begin
      cmd_complete_flag_next = 1'b1;
    end
    access_error_flag_next = access_error_flag_reg;
    if (seqErr || (stopReq && !cmd_complete_flag_reg)) begin
      access_error_flag_next = 1'b1;
    end else if (wrStat && hwdata[`FPS_BIT_ACCESS_ERROR_FLAG]) begin
      access_error_flag_next = 1'b0;
    end
    protection_violation_flag_next = protection_violation_flag_reg;
    if (protHit) begin
      protection_violation_flag_next = 1'b1;
    end else if (wrStat && hwdata[`FPS_BIT_PROTECTION_VIOLATION_FLAG]) begin
      protection_violation_flag_next = 1'b0;
    end
    blank_next = blank_reg;
    if (verifyBlank) begin
      blank_next = 1'b1;
    end else if (launch) begin
      blank_next = 1'b0;
    end
    fail_next = fail_reg;
    if (special_reg && verifyFail) begin
      fail_next = 1'b1;
    end else if (special_reg && wrStat && hwdata[`FPS_BIT_FAIL]) begin
      fail_next = 1'b0;
    end
  end

  // status and sequence state
  always @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      seq_reg <= SEQ_IDLE;
      bufFull_reg <= 1'b0;
      cmd_complete_flag_reg <= 1'b1;
      access_error_flag_reg <= 1'b0;
      protection_violation_flag_reg <= 1'b0;
      blank_reg <= 1'b0;
      fail_reg <= 1'b0;
      done_reg <= 1'b1;
      cmdCode_reg <= `FPS_RST_CMD;
    end else begin
      seq_reg <= seq_next;
      bufFull_reg <= bufFull_next;
      cmd_complete_flag_reg <= cmd_complete_flag_next;
      access_error_flag_reg <= access_error_flag_next;
      protection_violation_flag_reg <= protection_violation_flag_next;
      blank_reg <= blank_next;
      fail_reg <= fail_next;
      done_reg <= !engineBusy;
      cmdCode_reg <= cmdCode_next;
    end
  end

  fps_prot_guard uGuard (
    .curScen(protScenario),
    .reqScen(hwdata[2:0]),
    .allow(protAllow)
  );

  // configuration, divider and protection registers
  always @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      protScenario <= `FPS_RST_PROT;
      cfg_reg <= `FPS_RST_CFG;
      timebaseDiv <= `FPS_RST_DIV;
      divLoaded_reg <= 1'b0;
    end else begin
      if (wrStb && (xferSel_reg == SEL_PROT) && protAllow) begin
        protScenario <= hwdata[2:0];
      end
      if (wrStb && (xferSel_reg == SEL_CFG)) begin
        cfg_reg <= hwdata[`FPS_BIT_BEIE:`FPS_BIT_COMPLETE_IRQ_ENABLE];
      end
      if (wrStb && (xferSel_reg == SEL_DIV)) begin
        timebaseDiv <= hwdata[7:0];
        divLoaded_reg <= 1'b1;
      end
    end
  end

  // engine launch and interrupt request outputs
  always @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      launchValid <= 1'b0;
      launchCmd <= `FPS_RST_CMD;
      irqBufEmpty <= 1'b0;
      irqComplete <= 1'b0;
    end else begin
      launchValid <= bufFull_next;
      if (launch) begin
        launchCmd <= cmdCode_reg;
      end
      irqBufEmpty <= !bufFull_next && cfg_reg[1];
      irqComplete <= cmd_complete_flag_next && cfg_reg[0];
    end
  end

endmodule

// ---- verif/fps_ctrl_checker.sv ----
`timescale 1ns/1ps
`include "fps_map.vh"
module fps_ctrl_checker (
  input wire sys_clk,
  input wire rstn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  input wire engineTake,
  input wire launchValid,
  input wire [7:0] launchCmd,
  input wire [2:0] protScenario,
  input wire irqBufEmpty,
  input wire irqComplete
);
  localparam logic [63:0] ALLOW = 64'hff5a3c18080c0a0f;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // accepted address phases, split by target register
  wire acc = hsel && htrans[1] && hready;
  wire protWr = acc && hwrite && haddr[7:2] == `FPS_IDX_PROT;
  wire statWr = acc && hwrite && haddr[7:2] == `FPS_IDX_STAT;
  // one wait state, then ready again
  sequence waitState;
    !hreadyout ##1 hreadyout;
  endsequence
  sequence launchEdge;
    $rose(launchValid);
  endsequence
  // bus answers and register behaviour at the ports
  bus_wait_a: assert property (acc |=> waitState)
    else $error("wait state missing");
  okay_resp_a: assert property (hresp == 1'b0)
    else $error("response not okay");
  upper_zero_a: assert property (hrdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  prot_legal_a: assert property (!$stable(protScenario)
    |-> ALLOW[{$past(protScenario), protScenario}])
    else $error("forbidden protection change");
  prot_cause_a: assert property (!$stable(protScenario)
    |-> $past(protWr) || $past(protWr, 2))
    else $error("protection changed without a write");
  launch_cause_a: assert property (launchEdge
    |-> $past(statWr) || $past(statWr, 2))
    else $error("launch without status write");
  launch_code_a: assert property (launchEdge
    |-> launchCmd inside {8'h05, 8'h20, 8'h40, 8'h41})
    else $error("illegal code launched");
  take_clear_a: assert property (launchValid && engineTake
    |=> !launchValid)
    else $error("buffer not emptied by fetch");
  drop_cause_a: assert property ($fell(launchValid)
    |-> $past(engineTake))
    else $error("buffer emptied without fetch");
  irq_empty_a: assert property (irqBufEmpty |-> !launchValid)
    else $error("empty irq while buffer full");
  irq_done_a: assert property (irqComplete |-> !launchValid)
    else $error("complete irq while buffer full");
endmodule

bind fps_ctrl fps_ctrl_checker fps_ctrl_checker_i (.sys_clk, .rstn, .hsel,
  .haddr, .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp,
  .engineTake, .launchValid, .launchCmd, .protScenario, .irqBufEmpty,
  .irqComplete);

// ---- verif/testbench.sv ----
`timescale 1ns/1ps
`include "fps_map.vh"
module testbench;
  logic sys_clk = 0;
  logic rstn = 0;
  logic hsel = 0;
  logic hwrite = 0;
  logic spec = 0;
  logic busy = 0;
  logic [1:0] htrans = 0;
  logic [31:0] haddr = 0;
  logic [31:0] hwdata = 0;
  logic [31:0] hrdata;
  logic [6:0] ev = 0;
  logic hreadyout, hresp, launchValid, irqB, irqC;
  logic [7:0] launchCmd, div, rd;
  logic [2:0] prot;
  logic [63:0] allowMap = 64'hff5a3c18080c0a0f;
  int err_count = 0;
  int total_checks = 0;
  int cyc = 0;

  // 40 MHz clock
  initial forever #12.5 sys_clk = ~sys_clk;

  // ev bits: word write, fetch, done, hit, blank, fail, stop
  fps_ctrl fps_ctrl_i (.sys_clk, .rstn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp,
    .specialModePin(spec), .flashWordWr(ev[0]), .engineTake(ev[1]),
    .engineBusy(busy), .engineDone(ev[2]), .protHit(ev[3]),
    .verifyBlank(ev[4]), .verifyFail(ev[5]), .stopReq(ev[6]),
    .launchValid, .launchCmd, .protScenario(prot), .timebaseDiv(div),
    .irqBufEmpty(irqB), .irqComplete(irqC));

  task automatic print_verdict;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // hang guard
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      print_verdict();
    end
  end

  task automatic chk(input [7:0] g, input [7:0] e);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // one single word transfer, waits for ready in both phases
  task automatic bus(input w, input [5:0] i, input [7:0] d);
    @(posedge sys_clk);
    hsel <= 1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, i, 2'h0};
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    rd = hrdata[7:0];
  endtask

  task automatic rr(input [5:0] i, input [7:0] e);
    bus(0, i, 8'h00);
    chk(rd, e);
  endtask

  task automatic pu(input [6:0] m);
    @(posedge sys_clk);
    ev <= m;
    @(posedge sys_clk);
    ev <= 7'h00;
  endtask

  // word write, command, then launch by writing one to bit 7
  task automatic seq(input [7:0] c);
    pu(7'h01);
    bus(1, 6, c);
    bus(1, 5, 8'h80);
    wt(2);
  endtask

  task automatic rst;
    rstn <= 0;
    wt(12);
    rstn <= 1;
    wt(3);
  endtask

  // main sequence
  initial begin
    rst();
    rr(5, 8'hc0);
    rr(4, 8'h07);
    rr(6'h3f, 8'h00);
    bus(1, 3, 8'hc0);
    bus(1, 5, 8'h7f);
    rr(5, 8'hc0);
    chk({6'h0, irqB, irqC}, 8'h03);
    bus(1, 2, 8'h10);
    chk(div, 8'h10);
    seq(8'h20);
    chk({irqB, launchCmd[6:0]}, 8'h20);
    rr(5, 8'h00);
    pu(7'h02);
    rr(5, 8'h80);
    seq(8'h40);
    pu(7'h06);
    rr(5, 8'h80);
    pu(7'h04);
    rr(5, 8'hc0);
    chk({7'h0, irqC}, 8'h01);
    seq(8'h05);
    pu(7'h02);
    pu(7'h10);
    pu(7'h04);
    rr(5, 8'hc4);
    bus(1, 5, 8'h04);
    rr(5, 8'hc4);
    seq(8'h05);
    rr(5, 8'h00);
    pu(7'h02);
    pu(7'h04);
    rr(5, 8'hc0);
    spec <= 1;
    busy <= 1;
    wt(4);
    rr(5, 8'hc0);
    busy <= 0;
    wt(4);
    rr(5, 8'hc1);
    seq(8'h05);
    pu(7'h02);
    pu(7'h24);
    rr(5, 8'hc3);
    bus(1, 5, 8'h01);
    rr(5, 8'hc3);
    seq(8'h20);
    chk({7'h0, launchValid}, 8'h00);
    rr(5, 8'hd3);
    bus(1, 5, 8'h12);
    rr(5, 8'hc1);
    spec <= 0;
    wt(4);
    pu(7'h08);
    rr(5, 8'he0);
    seq(8'h20);
    chk({7'h0, launchValid}, 8'h00);
    bus(1, 5, 8'h30);
    rr(5, 8'hc0);
    pu(7'h01);
    bus(1, 5, 8'h00);
    rr(5, 8'hd0);
    seq(8'h20);
    chk({7'h0, launchValid}, 8'h00);
    bus(1, 5, 8'h10);
    rr(5, 8'hc0);
    seq(8'h33);
    rr(5, 8'hd0);
    bus(1, 5, 8'h10);
    seq(8'h20);
    pu(7'h40);
    rr(5, 8'h10);
    pu(7'h02);
    pu(7'h04);
    bus(1, 5, 8'h10);
    rr(5, 8'hc0);
    rst();
    seq(8'h20);
    rr(5, 8'hd0);
    // every source and target scenario, each from a fresh reset
    for (int f = 0; f < 8; f++) begin
      for (int t = 0; t < 8; t++) begin
        rst();
        bus(1, 4, 8'(f));
        bus(1, 4, 8'(t));
        rr(4, allowMap[f * 8 + t] ? 8'(t) : 8'(f));
        chk({5'h0, prot}, allowMap[f * 8 + t] ? 8'(t) : 8'(f));
      end
    end
    print_verdict();
  end
endmodule
